// *** bench/dacs_host.sv ***
// Purpose: Host software model on the byte port
// Assumes: Cycles change on the falling edge
// Notes: Idle lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dacs_host (
    input wire logic clk,
    output var dacs_pkg::dacs_io_req_t io_req,
    input wire logic [7:0] io_rdata
);
    import dacs_pkg::*;
    initial io_req = '0;
    // Callers set one trigger enable at a time
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        io_req <= '{1'b1, 1'b0, a, d};
        @(negedge clk);
        io_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        io_req <= '{1'b0, 1'b1, a, io_req.wdata};
        @(negedge clk);
        // Read data stands for one cycle only, take it before release
        d = io_rdata;
        io_req <= '{1'b0, 1'b0, ~a, ~io_req.wdata};
    endtask : rd
endmodule : dacs_host
`default_nettype wire

// *** bench/dacs_regs_sva.sv ***
// Purpose: Port checks of dacs_regs
// Assumes: Bound from the bench top
// Notes: Latencies as in the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module dacs_regs_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire dacs_pkg::dacs_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic soft_trig_req,
    input wire logic pacer_tick,
    input wire logic ext_trig_pin,
    input wire logic conv_done,
    input wire logic fifo_empty,
    input wire logic fifo_half,
    input wire logic fifo_full,
    input wire logic conv_start,
    input wire logic fifo_clear,
    input wire logic irq_out,
    input wire dacs_pkg::dacs_acq_cfg_t acq_cfg
);
    import dacs_pkg::*;
    wire w6 = io_req.wr && io_req.addr == 4'h6;
    wire w7 = io_req.wr && io_req.addr == 4'h7;
    wire w8 = io_req.wr && io_req.addr == 4'h8;
    wire w9 = io_req.wr && io_req.addr == 4'h9;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ====================
    // Host port
    property p_stat; io_req.rd && io_req.addr == 4'h7 |=>
        io_rdata[2:0] == $past({fifo_full, fifo_half, fifo_empty}); endproperty
    a_stat: assert property (p_stat) else $error("flag byte off");
    property p_cfg; w6 |=> {acq_cfg.counter_zero_clock_select, acq_cfg.input_resolution_select}
        == $past({io_req.wdata[6], io_req.wdata[7]}); endproperty
    a_cfg: assert property (p_cfg) else $error("cfg off");
    property p_cal; w7 |=> acq_cfg.cal_mode == $past(io_req.wdata[7]); endproperty
    a_cal: assert property (p_cal) else $error("cal off");
    property p_fclr; fifo_clear == $past(w9); endproperty
    a_fclr: assert property (p_fclr) else $error("fifo clear off");
    // ====================
    // Triggers and interrupt
    property p_trig; conv_start |-> $past(soft_trig_req) || $past(pacer_tick) || $past(ext_trig_pin, 3); endproperty
    a_trig: assert property (p_trig) else $error("stray start");
    property p_iclr; w8 && !conv_done && !fifo_half |=> !irq_out; endproperty
    a_iclr: assert property (p_iclr) else $error("irq kept");
    property p_ihold; irq_out && !w8 && !w6 && !$past(w6) |=> irq_out; endproperty
    a_ihold: assert property (p_ihold) else $error("irq dropped");
    property p_irise; $rose(irq_out) |-> $past(conv_done) || $past(fifo_half) || $past(w6) || $past(w6, 2); endproperty
    a_irise: assert property (p_irise) else $error("stray irq");
endmodule : dacs_regs_sva
`default_nettype wire

// *** bench/dacs_regs_test.sv ***
// Purpose: Self-checking bench of dacs_regs
// Assumes: Inputs change on the falling edge
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
module dacs_regs_test;
    import dacs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic soft_trig_req = 1'b0, pacer_tick = 1'b0, ext_trig_pin = 1'b0, ext_gate_pin = 1'b0;
    logic conv_done = 1'b0, fifo_empty = 1'b1, fifo_half = 1'b0, fifo_full = 1'b0;
    logic [7:0] io_rdata, r;
    logic io_rvalid, conv_start, fifo_clear, irq_out, h;
    dacs_io_req_t io_req;
    dacs_acq_cfg_t acq_cfg;
    dacs_ao_t ao0_out, ao1_out;
    int n_fail = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    dacs_regs DUT (.clk, .rstn, .io_req, .io_rdata, .io_rvalid, .soft_trig_req, .pacer_tick, .ext_trig_pin,
        .ext_gate_pin, .conv_done, .fifo_empty, .fifo_half, .fifo_full, .conv_start, .fifo_clear, .irq_out,
        .acq_cfg, .ao0_out, .ao1_out);
    dacs_host host (.clk, .io_req, .io_rdata);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        h = conv_start;
    endtask : pulse
    task automatic pin();
        h = 1'b0;
        ext_trig_pin = 1'b1;
        repeat (6) @(negedge clk) h |= conv_start;
        ext_trig_pin = 1'b0;
        repeat (4) @(negedge clk);
    endtask : pin
    // ====================
    // Scenarios
    task automatic t_ctrl();
        logic [7:0] v [4] = '{8'h01, 8'hC2, 8'h7C, 8'h81};
        host.rd(4'h6, r);
        chk("rvalid", 1, io_rvalid);
        chk("ctrl rst", 8'h00, r);
        foreach (v[i]) begin
            host.wr(4'h6, v[i]);
            host.rd(4'h6, r);
            chk("ctrl", v[i], r);
            chk("cfg", {v[i][6], v[i][7]}, {acq_cfg.counter_zero_clock_select, acq_cfg.input_resolution_select});
        end
    endtask : t_ctrl
    task automatic t_trig();
        host.wr(4'h6, 8'h00);
        pulse(soft_trig_req);
        chk("soft off", 0, h);
        pin();
        chk("pin off", 0, h);
        host.wr(4'h6, 8'h01);
        pulse(soft_trig_req);
        chk("soft on", 1, h);
        pulse(pacer_tick);
        chk("pacer off", 0, h);
        host.wr(4'h6, 8'h0A);
        pulse(pacer_tick);
        chk("gate shut", 0, h);
        ext_gate_pin = 1'b1;
        repeat (3) @(negedge clk);
        pulse(pacer_tick);
        chk("pacer on", 1, h);
        host.wr(4'h6, 8'h04);
        pin();
        chk("pin on", 1, h);
    endtask : t_trig
    task automatic t_stat();
        {fifo_full, fifo_half, fifo_empty} = 3'b110;
        host.rd(4'h7, r);
        chk("flags", 3'b110, r[2:0]);
        {fifo_full, fifo_half, fifo_empty} = 3'b001;
        host.wr(4'h7, 8'h80);
        host.rd(4'h7, r);
        chk("flags cal", 4'h9, {r[7], r[2:0]});
        host.wr(4'h7, 8'h00);
        chk("cal off", 0, acq_cfg.cal_mode);
        host.rd(4'hE, r);
        chk("wo read", 8'h00, r);
    endtask : t_stat
    task automatic t_irq();
        host.wr(4'h8, 8'h5A);
        host.wr(4'h6, 8'h10);
        pulse(conv_done);
        repeat (3) @(negedge clk);
        chk("irq conv", 1, irq_out);
        host.rd(4'h7, r);
        chk("pending", 1, r[3]);
        host.wr(4'h8, 8'h00);
        chk("irq clr", 0, irq_out);
        host.wr(4'h6, 8'h30);
        pulse(conv_done);
        chk("irq cause", 0, irq_out);
        fifo_half = 1'b1;
        @(negedge clk);
        fifo_half = 1'b0;
        chk("irq half", 1, irq_out);
        host.wr(4'h6, 8'h20);
        host.rd(4'h7, r);
        chk("masked", 2'b01, {irq_out, r[3]});
        host.wr(4'h9, 8'hFF);
        chk("fifo clr", 1, fifo_clear);
    endtask : t_irq
    task automatic t_ao();
        host.wr(4'hE, 8'h05);
        host.wr(4'hF, 8'h02);
        host.wr(4'hA, 8'h34);
        host.wr(4'hB, 8'hC2);
        host.wr(4'hC, 8'hBC);
        host.wr(4'hD, 8'h9A);
        @(negedge clk);
        chk("ao0", 19'h611A6, ao0_out);
        chk("ao1", 19'h4D5E1, ao1_out);
        host.wr(4'hE, 8'h0D);
        host.wr(4'hF, 8'h0A);
        host.wr(4'hA, 8'h78);
        host.wr(4'hD, 8'h11);
        @(negedge clk);
        chk("ao0 held", 16'hC234, ao0_out.analog_out_word);
        chk("ao1 held", 16'h9ABC, ao1_out.analog_out_word);
        host.rd(4'hB, r);
        host.rd(4'hC, r);
        chk("ao0 load", 16'hC278, ao0_out.analog_out_word);
        chk("ao1 load", 16'h11BC, ao1_out.analog_out_word);
    endtask : t_ao
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_ctrl();
        t_trig();
        t_stat();
        t_irq();
        t_ao();
        final_report();
    end
    initial begin
        #50000;
        n_fail++;
        final_report();
    end
endmodule : dacs_regs_test
bind dacs_regs dacs_regs_sva u_sva (.clk, .rstn, .io_req, .io_rdata, .soft_trig_req, .pacer_tick, .ext_trig_pin,
    .conv_done, .fifo_empty, .fifo_half, .fifo_full, .conv_start, .fifo_clear, .irq_out, .acq_cfg);
`default_nettype wire

// *** design/dacs_regs.sv ***
// Purpose: Byte-wide control and status register bank of an acquisition card
// Assumes: Host I/O strobes and FIFO flags are synchronous to clk
// Notes: Trigger and gate pins are asynchronous and pass two flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "dacs_cfg.svh"

module dacs_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire dacs_pkg::dacs_io_req_t io_req,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic soft_trig_req,
    input wire logic pacer_tick,
    input wire logic ext_trig_pin,
    input wire logic ext_gate_pin,
    input wire logic conv_done,
    input wire logic fifo_empty,
    input wire logic fifo_half,
    input wire logic fifo_full,
    output logic conv_start,
    output logic fifo_clear,
    output logic irq_out,
    output dacs_pkg::dacs_acq_cfg_t acq_cfg,
    output dacs_pkg::dacs_ao_t ao0_out,
    output dacs_pkg::dacs_ao_t ao1_out
);
    import dacs_pkg::*;

    // ==============================================================
    // Helpers
    function automatic logic hit(input logic [`DACS_ADDR_W-1:0] a, input logic [`DACS_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // Byte lane update of a staged output word
    function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi, input logic [7:0] d);
        put_byte = hi ? {d, w[7:0]} : {w[15:8], d};
    endfunction : put_byte

    // ==============================================================
    // Reset release
    logic rst_s1_n;
    logic rst_n;

    // Async assert, clocked release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_n <= 1'b1;
            rst_n <= rst_s1_n;
        end
    end

    // ==============================================================
    // State
    dacs_state_t q;
    dacs_state_t n;

    logic wr;
    logic rd;
    logic pin_edge;
    logic gate_ok;
    logic irq_event;
    logic clr_irq;

    always_comb begin
        n = q;
        wr = io_req.wr;
        rd = io_req.rd;
        clr_irq = 1'b0;

        // Pin synchronisers; only the second stage and the trigger pin's edge flop are looked at
        n.pin_s1 = ext_trig_pin;
        n.pin_s2 = q.pin_s1;
        n.pin_prev = q.pin_s2;
        n.gate_s1 = ext_gate_pin;
        n.gate_s2 = q.gate_s1;

        // Register writes
        n.fifo_clear = 1'b0;
        if (wr) begin
            if (hit(io_req.addr, `DACS_OFF_CTRL)) begin
                n.ctrl = io_req.wdata;
            end
            if (hit(io_req.addr, `DACS_OFF_STAT)) begin
                n.cal = io_req.wdata[`DACS_SB_CAL];
            end
            if (hit(io_req.addr, `DACS_OFF_IRQ_CLR)) begin
                clr_irq = 1'b1;
            end
            if (hit(io_req.addr, `DACS_OFF_FIFO_CLR)) begin
                n.fifo_clear = 1'b1;
            end
            if (hit(io_req.addr, `DACS_OFF_AO0_LO) || hit(io_req.addr, `DACS_OFF_AO0_HI)) begin
                n.stage0 = put_byte(q.stage0, io_req.addr[0], io_req.wdata);
            end
            if (hit(io_req.addr, `DACS_OFF_AO1_LO) || hit(io_req.addr, `DACS_OFF_AO1_HI)) begin
                n.stage1 = put_byte(q.stage1, io_req.addr[0], io_req.wdata);
            end
            if (hit(io_req.addr, `DACS_OFF_REF_LO)) begin
                n.ref_ctrl[7:0] = io_req.wdata;
            end
            if (hit(io_req.addr, `DACS_OFF_REF_HI)) begin
                n.ref_ctrl[15:8] = io_req.wdata;
            end
        end

        // Output loading, gated loads wait for a read of the data pair
        if (!q.ref_ctrl[`DACS_RF_LDEN]) begin
            n.ao0 = n.stage0;
        end else if (rd && (hit(io_req.addr, `DACS_OFF_AO0_LO) || hit(io_req.addr, `DACS_OFF_AO0_HI))) begin
            n.ao0 = q.stage0;
        end
        if (!q.ref_ctrl[`DACS_RF_CH1 + `DACS_RF_LDEN]) begin
            n.ao1 = n.stage1;
        end else if (rd && (hit(io_req.addr, `DACS_OFF_AO1_LO) || hit(io_req.addr, `DACS_OFF_AO1_HI))) begin
            n.ao1 = q.stage1;
        end

        // Trigger selection; overlapping enables are the host's fault
        pin_edge = q.pin_s2 & ~q.pin_prev;
        gate_ok = ~q.ctrl[`DACS_CB_GATE] | q.gate_s2;
        n.conv_start = gate_ok & ((q.ctrl[`DACS_CB_SOFT] & soft_trig_req)
            | (q.ctrl[`DACS_CB_PACER] & pacer_tick)
            | (q.ctrl[`DACS_CB_PIN] & pin_edge));

        // Interrupt cause and pending flag, a new event beats the clear
        n.half_prev = fifo_half;
        irq_event = q.ctrl[`DACS_CB_CAUSE] ? (fifo_half & ~q.half_prev) : conv_done;
        if (clr_irq) begin
            n.irq_pend = 1'b0;
        end
        if (irq_event) begin
            n.irq_pend = 1'b1;
        end
        n.irq_out = n.irq_pend & n.ctrl[`DACS_CB_INTERRUPT_ENABLE_BIT];

        // Read data, unmapped and write-only offsets read zero
        n.rvalid = rd;
        n.rdata = 8'h00;
        if (rd) begin
            if (hit(io_req.addr, `DACS_OFF_CTRL)) begin
                n.rdata = q.ctrl;
            end else if (hit(io_req.addr, `DACS_OFF_STAT)) begin
                n.rdata[`DACS_SB_EMPTY] = fifo_empty;
                n.rdata[`DACS_SB_HALF] = fifo_half;
                n.rdata[`DACS_SB_FULL] = fifo_full;
                n.rdata[`DACS_SB_IRQ] = q.irq_pend;
                n.rdata[`DACS_SB_CAL] = q.cal;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.ctrl <= `DACS_RST_CTRL;
            q.ref_ctrl <= `DACS_RST_REF;
            q.stage0 <= `DACS_RST_AO;
            q.stage1 <= `DACS_RST_AO;
            q.ao0 <= `DACS_RST_AO;
            q.ao1 <= `DACS_RST_AO;
        end else begin
            q <= n;
        end
    end

    // ==============================================================
    // Outputs, all straight from state
    assign io_rdata = q.rdata;
    assign io_rvalid = q.rvalid;
    assign conv_start = q.conv_start;
    assign fifo_clear = q.fifo_clear;
    assign irq_out = q.irq_out;
    // One driver per output struct, member-wise drivers are not portable
    assign acq_cfg = '{
        counter_zero_clock_select: q.ctrl[`DACS_CB_COUNTER_ZERO_CLOCK_SELECT],
        input_resolution_select: q.ctrl[`DACS_CB_RES],
        cal_mode: q.cal
    };
    assign ao0_out = '{
        analog_out_word: q.ao0,
        analog_out_ref_range: q.ref_ctrl[`DACS_RF_RANGE],
        analog_out_ref_source: q.ref_ctrl[`DACS_RF_SRC],
        analog_out_polarity: q.ref_ctrl[`DACS_RF_POL]
    };
    assign ao1_out = '{
        analog_out_word: q.ao1,
        analog_out_ref_range: q.ref_ctrl[`DACS_RF_CH1 + `DACS_RF_RANGE],
        analog_out_ref_source: q.ref_ctrl[`DACS_RF_CH1 + `DACS_RF_SRC],
        analog_out_polarity: q.ref_ctrl[`DACS_RF_CH1 + `DACS_RF_POL]
    };

endmodule : dacs_regs
`default_nettype wire

// *** include/dacs_cfg.svh ***
// Purpose: Offsets, field positions, reset values for the acquisition register bank
// Assumes: Byte-wide host I/O port, offsets relative to the card base
// Notes: Definitions only
//
// What this block does
// - Software trigger starts a conversion only while control bit 0 is set.
// - Periodic timer triggers are accepted only while control bit 1 is set.
// - External pin triggers are accepted only while control bit 2 is set.
// - External gating of conversions applies only while control bit 3 is set.
// - Control bit 5 selects interrupt cause: each conversion, or FIFO half full.
// - Control bit 6 selects counter zero clock: internal or external pin.
// - Control bit 7 selects input width: 0 gives 16 bit, 1 gives 12 bit.
// - Bit 7 of offset 7 reroutes inputs into calibration wiring.
// - Reading offset 6 returns the control byte last written.
// - Offset 7 bit 0 reads 1 while the sample FIFO is empty.
// - Offset 7 bit 1 reads 1 while the sample FIFO is half full.
// - Offset 7 bit 2 reads 1 while the sample FIFO is full.
// - Offset 7 bit 3 reads 1 once an interrupt condition has occurred.
// - Any write to 8 clears interrupt; any write to 9 empties FIFO.
// - Channel 0 output loads on write, or on read of 10/11 when gated.
// - Channel 1 output loads on write, or on read of 12/13 when gated.
// - Offsets 10 and 11 hold channel 0 data, bit 0 the LSB.
// - Offsets 12 and 13 hold channel 1 data in the same layout.
// - Reference range bit per channel: 0 selects -5 V, 1 selects -10 V.
// - Reference source bit per channel: 0 internal, 1 external.
`ifndef DACS_CFG_SVH
`define DACS_CFG_SVH

// ==================================================================
// Widths
`define DACS_ADDR_W 4
`define DACS_AO_W 16

// ==================================================================
// Offsets
`define DACS_OFF_CTRL 4'h6
`define DACS_OFF_STAT 4'h7
`define DACS_OFF_IRQ_CLR 4'h8
`define DACS_OFF_FIFO_CLR 4'h9
`define DACS_OFF_AO0_LO 4'hA
`define DACS_OFF_AO0_HI 4'hB
`define DACS_OFF_AO1_LO 4'hC
`define DACS_OFF_AO1_HI 4'hD
`define DACS_OFF_REF_LO 4'hE
`define DACS_OFF_REF_HI 4'hF

// ==================================================================
// Control byte fields
`define DACS_CB_SOFT 0
`define DACS_CB_PACER 1
`define DACS_CB_PIN 2
`define DACS_CB_GATE 3
`define DACS_CB_INTERRUPT_ENABLE_BIT 4
`define DACS_CB_CAUSE 5
`define DACS_CB_COUNTER_ZERO_CLOCK_SELECT 6
`define DACS_CB_RES 7

// ==================================================================
// Status byte fields
`define DACS_SB_EMPTY 0
`define DACS_SB_HALF 1
`define DACS_SB_FULL 2
`define DACS_SB_IRQ 3
`define DACS_SB_CAL 7

// ==================================================================
// Reference control fields, channel 1 sits eight bits higher
`define DACS_RF_RANGE 0
`define DACS_RF_POL 1
`define DACS_RF_SRC 2
`define DACS_RF_LDEN 3
`define DACS_RF_CH1 8

// ==================================================================
// Reset values
`define DACS_RST_CTRL 8'h00
`define DACS_RST_REF 16'h0000
`define DACS_RST_AO 16'h0000

`endif

// *** include/dacs_pkg.sv ***
// Purpose: Types for the acquisition register bank
// Assumes: dacs_cfg.svh on the include path
// Notes: All state but the reset release flops lives in one packed struct
`include "dacs_cfg.svh"

package dacs_pkg;

    // ==============================================================
    // Host I/O request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`DACS_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } dacs_io_req_t;

    // ==============================================================
    // Acquisition settings toward the analog front end
    typedef struct packed {
        logic counter_zero_clock_select;
        logic input_resolution_select;
        logic cal_mode;
    } dacs_acq_cfg_t;

    // ==============================================================
    // Analog output channel
    typedef struct packed {
        logic [`DACS_AO_W-1:0] analog_out_word;
        logic analog_out_ref_range;
        logic analog_out_ref_source;
        logic analog_out_polarity;
    } dacs_ao_t;

    // ==============================================================
    // Module state apart from the reset release flops
    typedef struct packed {
        logic [7:0] ctrl;
        logic cal;
        logic [15:0] ref_ctrl;
        logic [`DACS_AO_W-1:0] stage0;
        logic [`DACS_AO_W-1:0] stage1;
        logic [`DACS_AO_W-1:0] ao0;
        logic [`DACS_AO_W-1:0] ao1;
        logic irq_pend;
        logic irq_out;
        logic half_prev;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic gate_s1;
        logic gate_s2;
        logic conv_start;
        logic fifo_clear;
        logic [7:0] rdata;
        logic rvalid;
    } dacs_state_t;

endpackage : dacs_pkg
